// file: mrst_pkg.sv
/*
  Package for the manual reset pulse stretcher: timing constants and states.
  Assumes a 10 MHz core clock; counts are derived from the nominal times.
*/
package mrst_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ               = 10_000_000;
  localparam int unsigned RESET_TIMEOUT_MS     = 200;
  localparam int unsigned RESET_TIMEOUT_CYCLES = (RESET_TIMEOUT_MS * (CLK_HZ / 1000));
  localparam int unsigned CNT_W                = 24;

  // ---------------------------------------------------------------
  // Stretcher states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_STRETCH = 3'h2,
    ST_HELD    = 3'h4
  } state_t;

endpackage : mrst_pkg

// file: manual_reset_pulse_stretcher.sv
/*
  Manual reset pulse stretcher for a supervisory device with embedded memory.
  Assumes both reset pins arrive asynchronously (pushbutton or external logic)
  and that the memory controller honours mem_enable_out and ack_block_out.
*/
// Function
// - Either reset pin accepts a manual reset
// - Only the asserting edge is sensed
// - Edge starts 200 ms count, output asserted
// - Output released at expiry despite held input
// - Memory disabled while any reset persists
// - Acknowledge withheld while input held past timeout
`timescale 1ns/1ps

module manual_reset_pulse_stretcher #(
  parameter int unsigned RESET_TIMEOUT_CYCLES = mrst_pkg::RESET_TIMEOUT_CYCLES
) (
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  input  wire logic rst_hi_pin_in,
  input  wire logic rst_lo_n_pin_in,
  output logic      rst_hi_drive_out,
  output logic      rst_lo_n_drive_out,
  output logic      mem_enable_out,
  output logic      ack_block_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                 hi_sync;
    logic [1:0]                 lo_sync;
    logic                       hi_prev;
    logic                       lo_prev;
    mrst_pkg::state_t           state;
    logic                       src_hi;   // Which pin started the stretch
    logic [mrst_pkg::CNT_W-1:0] cnt;
    logic                       hi_drv;
    logic                       lo_n_drv;
    logic                       mem_en;
    logic                       ack_blk;
  } regs_t;

  localparam logic [mrst_pkg::CNT_W-1:0] LAST_CNT = mrst_pkg::CNT_W'(RESET_TIMEOUT_CYCLES - 1);

  regs_t regs_r;
  regs_t regs_nxt;

  logic hi_s;
  logic lo_s;
  logic hi_rise;
  logic lo_fall;
  logic input_active;
  logic stretch_nxt;

  // Synchronised levels, read only past the second stage
  assign hi_s         = regs_r.hi_sync[1];
  assign lo_s         = regs_r.lo_sync[1];
  assign hi_rise      = hi_s & ~regs_r.hi_prev;
  assign lo_fall      = ~lo_s & regs_r.lo_prev;
  assign input_active = regs_r.src_hi ? hi_s : ~lo_s;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    regs_nxt         = regs_r;
    regs_nxt.hi_sync = {regs_r.hi_sync[0], rst_hi_pin_in};
    regs_nxt.lo_sync = {regs_r.lo_sync[0], rst_lo_n_pin_in};
    regs_nxt.hi_prev = hi_s;
    regs_nxt.lo_prev = lo_s;
    stretch_nxt      = 1'b0;
    unique case (regs_r.state)
      mrst_pkg::ST_IDLE: begin
        // Level alone never triggers; only an edge does
        if (hi_rise || lo_fall) begin
          regs_nxt.state  = mrst_pkg::ST_STRETCH;
          regs_nxt.src_hi = hi_rise;
          regs_nxt.cnt    = '0;
          stretch_nxt     = 1'b1;
        end
      end
      mrst_pkg::ST_STRETCH: begin
        stretch_nxt = 1'b1;
        if (regs_r.cnt == LAST_CNT) begin
          stretch_nxt    = 1'b0;
          regs_nxt.state = input_active ? mrst_pkg::ST_HELD : mrst_pkg::ST_IDLE;
        end else begin
          // Counter never passes LAST_CNT, so it cannot wrap
          regs_nxt.cnt = regs_r.cnt + mrst_pkg::CNT_W'(1);
        end
      end
      mrst_pkg::ST_HELD: begin
        // New edges ignored until the held input is released
        if (!input_active) begin
          regs_nxt.state = mrst_pkg::ST_IDLE;
        end
      end
      default: begin
        regs_nxt.state = mrst_pkg::ST_IDLE;
      end
    endcase
    // Complementary pin is driven; the source pin stays an input
    regs_nxt.hi_drv   = stretch_nxt & ~regs_nxt.src_hi;
    regs_nxt.lo_n_drv = ~(stretch_nxt & regs_nxt.src_hi);
    // Any reset on either pin keeps memory off.
    // Only the second synchroniser stage is read here: the first stage
    // may still be metastable, and a glitch would reach the memory enable.
    // Costs one cycle of extra memory-off latency after a pin change.
    regs_nxt.mem_en   = ~(stretch_nxt | hi_s | ~lo_s);
    regs_nxt.ack_blk  = (regs_nxt.state == mrst_pkg::ST_HELD) | ~regs_nxt.mem_en;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      regs_r          <= '0;
      regs_r.lo_sync  <= 2'h3;
      regs_r.lo_prev  <= 1'b1;
      regs_r.state    <= mrst_pkg::ST_IDLE;
      regs_r.lo_n_drv <= 1'b1;
      regs_r.ack_blk  <= 1'b1;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  assign rst_hi_drive_out   = regs_r.hi_drv;
  assign rst_lo_n_drive_out = regs_r.lo_n_drv;
  assign mem_enable_out     = regs_r.mem_en;
  assign ack_block_out      = regs_r.ack_blk;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  edge_starts_a: assert property (regs_r.state == mrst_pkg::ST_IDLE && (hi_rise || lo_fall)
    |=> regs_r.state == mrst_pkg::ST_STRETCH) else $error("edge did not start stretch");
  idle_no_start_a: assert property (regs_r.state == mrst_pkg::ST_IDLE && !hi_rise && !lo_fall
    |=> regs_r.state == mrst_pkg::ST_IDLE) else $error("stretch without edge");
  out_during_a: assert property (regs_r.state == mrst_pkg::ST_STRETCH
    |-> (rst_hi_drive_out != regs_r.src_hi) || !rst_lo_n_drive_out) else $error("output not active");
  count_end_a: assert property (regs_r.state == mrst_pkg::ST_STRETCH && regs_r.cnt == LAST_CNT
    |=> !rst_hi_drive_out && rst_lo_n_drive_out) else $error("output not released");
  count_step_a: assert property (regs_r.state == mrst_pkg::ST_STRETCH && regs_r.cnt != LAST_CNT
    |=> regs_r.cnt == $past(regs_r.cnt) + 1'b1) else $error("count stalled");
  mem_off_a: assert property (hi_s || !lo_s |=> !mem_enable_out) else $error("memory on in reset");
  held_block_a: assert property (regs_r.state == mrst_pkg::ST_HELD |-> ack_block_out)
    else $error("ack not blocked");
  one_pin_a: assert property (!(rst_hi_drive_out && !rst_lo_n_drive_out))
    else $error("both pins driven");

  // ---------------------------------------------------------------
  // Drive and state checks
  // ---------------------------------------------------------------
  // A stretch from the high pin drives only the low pin
  hi_src_drive_a: assert property (regs_r.state == mrst_pkg::ST_STRETCH && regs_r.src_hi
    |-> !rst_lo_n_drive_out && !rst_hi_drive_out) else $error("wrong pin for high source");
  // A stretch from the low pin drives only the high pin
  lo_src_drive_a: assert property (regs_r.state == mrst_pkg::ST_STRETCH && !regs_r.src_hi
    |-> rst_hi_drive_out && rst_lo_n_drive_out) else $error("wrong pin for low source");
  // In idle both drives are inactive
  idle_quiet_a: assert property (regs_r.state == mrst_pkg::ST_IDLE
    |-> !rst_hi_drive_out && rst_lo_n_drive_out) else $error("drive active in idle");
  // A held input must not keep the drive active
  held_quiet_a: assert property (regs_r.state == mrst_pkg::ST_HELD
    |-> !rst_hi_drive_out && rst_lo_n_drive_out) else $error("drive active while held");
  // Release of the held input returns to idle next cycle
  held_exit_a: assert property (regs_r.state == mrst_pkg::ST_HELD && !input_active
    |=> regs_r.state == mrst_pkg::ST_IDLE) else $error("held state not left");
  // While the input stays active the block stays held
  held_stay_a: assert property (regs_r.state == mrst_pkg::ST_HELD && input_active
    |=> regs_r.state == mrst_pkg::ST_HELD) else $error("held state left early");
  // Memory stays off for the whole stretch
  stretch_mem_a: assert property (regs_r.state == mrst_pkg::ST_STRETCH
    |-> !mem_enable_out) else $error("memory on during stretch");
  // Memory off always implies withheld acknowledge
  mem_ack_a: assert property (!mem_enable_out |-> ack_block_out)
    else $error("ack allowed with memory off");
  // Each stretch starts from a cleared count
  cnt_start_a: assert property (regs_r.state == mrst_pkg::ST_IDLE && (hi_rise || lo_fall)
    |=> regs_r.cnt == '0) else $error("count not cleared");
  // Count never runs past its last value
  cnt_bound_a: assert property (regs_r.state == mrst_pkg::ST_STRETCH
    |-> regs_r.cnt <= LAST_CNT) else $error("count overrun");
  // High-pin edge records the high pin as source
  src_hi_a: assert property (regs_r.state == mrst_pkg::ST_IDLE && hi_rise
    |=> regs_r.src_hi) else $error("high source lost");
  // Low-pin edge alone records the low pin as source
  src_lo_a: assert property (regs_r.state == mrst_pkg::ST_IDLE && lo_fall && !hi_rise
    |=> !regs_r.src_hi) else $error("low source lost");

  // Main scenarios: both pin sources, hold past expiry, memory recovery,
  // and a second press while a stretch runs
  stretch_hi_c: cover property (hi_rise ##1 regs_r.state == mrst_pkg::ST_STRETCH);
  stretch_lo_c: cover property (lo_fall ##1 regs_r.state == mrst_pkg::ST_STRETCH);
  held_c: cover property (regs_r.state == mrst_pkg::ST_HELD ##1 regs_r.state == mrst_pkg::ST_IDLE);
  mem_back_c: cover property (!mem_enable_out ##1 mem_enable_out);
  repress_c: cover property (regs_r.state == mrst_pkg::ST_STRETCH && lo_fall);

endmodule : manual_reset_pulse_stretcher

// file: pushbutton_model.sv
/*
  Pushbutton or outside logic that drives the two reset pins.
  Assumes the bench sets press levels just after a clock edge.
*/
`timescale 1ns/1ps
module pushbutton_model (
  input  wire logic hi_press_in,
  input  wire logic lo_press_in,
  output logic      rst_hi_pin_out,
  output logic      rst_lo_n_pin_out
);
  // ------
  // Pins
  // ------
  // Idle levels: high pin low, low pin high
  assign rst_hi_pin_out   = hi_press_in;
  assign rst_lo_n_pin_out = ~lo_press_in;
endmodule : pushbutton_model

// file: manual_reset_pulse_stretcher_test.sv
/*
  Self-checking bench for the manual reset pulse stretcher.
  Assumes a short stretch parameter and the pushbutton model.
*/
`timescale 1ns/1ps
module manual_reset_pulse_stretcher_test;
  localparam int unsigned N = 8;
  logic mclk_in = 1'b0, resetn_in = 1'b0, hi_press = 1'b0, lo_press = 1'b0;
  wire logic hi_pin, lo_n_pin, hi_drv, lo_n_drv, mem_en, ack_blk;
  int num_errors = 0, checks = 0, len;
  // ------
  // Clock and parts
  // ------
  always #50 mclk_in = ~mclk_in;
  pushbutton_model PB (.hi_press_in(hi_press), .lo_press_in(lo_press),
    .rst_hi_pin_out(hi_pin), .rst_lo_n_pin_out(lo_n_pin));
  manual_reset_pulse_stretcher #(.RESET_TIMEOUT_CYCLES(N)) DUT (.mclk_in(mclk_in),
    .resetn_in(resetn_in), .rst_hi_pin_in(hi_pin), .rst_lo_n_pin_in(lo_n_pin),
    .rst_hi_drive_out(hi_drv), .rst_lo_n_drive_out(lo_n_drv),
    .mem_enable_out(mem_en), .ack_block_out(ack_blk));
  // ------
  // Helpers
  // ------
  task automatic chk(input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Inputs always move 5 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #5;
  endtask : tick
  // Bounded wait for the drive, then count its active cycles
  task automatic stretch(input logic hi, output int n);
    int i;
    n = 0;
    for (i = 0; i < 10 && !(hi ? lo_n_drv === 1'b0 : hi_drv === 1'b1); i++) tick(1);
    while ((hi ? lo_n_drv === 1'b0 : hi_drv === 1'b1) && n < 40) begin
      n++;
      tick(1);
    end
    if (i == 10 || n == 40) begin
      num_errors++;
      summarize();
    end
  endtask : stretch
  task automatic summarize();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // ------
  // Scenarios
  // ------
  // High pin held far past the count: level must not retrigger
  task automatic test_held();
    hi_press = 1'b1;
    stretch(1'b1, len);
    chk(len == N || len == N + 1, 1'b1);
    tick(4);
    chk(lo_n_drv, 1'b1);
    chk(mem_en, 1'b0);
    chk(ack_blk, 1'b1);
    chk(hi_drv, 1'b0);
    hi_press = 1'b0;
    tick(4);
    chk(mem_en, 1'b1);
    chk(ack_blk, 1'b0);
    $display("test_held done");
  endtask : test_held
  // Low pin tapped, then tapped again mid-stretch: no restart
  task automatic test_repress();
    lo_press = 1'b1;
    tick(6);
    chk(hi_drv, 1'b1);
    chk(mem_en, 1'b0);
    lo_press = 1'b0;
    tick(1);
    lo_press = 1'b1;
    tick(1);
    lo_press = 1'b0;
    stretch(1'b0, len);
    chk(len < N, 1'b1);
    tick(3);
    chk(mem_en, 1'b1);
    $display("test_repress done");
  endtask : test_repress
  // ------
  // Main sequence
  // ------
  initial begin
    repeat (12) @(posedge mclk_in);
    #5;
    chk(mem_en, 1'b0);
    resetn_in = 1'b1;
    tick(2);
    test_held();
    test_repress();
    summarize();
  end
endmodule : manual_reset_pulse_stretcher_test
